// [core/poq_core.v]
// device-side packet, overlap and queue control with apb task file
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`include "poq_defines.vh"
`default_nettype none

module poq_core (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        dev_num,
  input  wire        eng_ready,
  input  wire [4:0]  eng_tag,
  input  wire        eng_error,
  output reg         intrq,
  output reg         serv_ready_out
);

  // command engine states
  localparam S_IDLE = 3'd0;
  localparam S_PREP = 3'd1;
  localparam S_PKT  = 3'd2;
  localparam S_EXEC = 3'd3;

  // engine state and visible status
  reg [2:0]  state_reg;
  reg [7:0]  stat_reg;
  reg [7:0]  err_reg;

  // task-file shadow registers
  reg [7:0]  feat_reg;
  reg [7:0]  scnt_reg;
  reg [7:0]  lbal_reg;
  reg [7:0]  lbam_reg;
  reg [7:0]  lbah_reg;
  reg [7:0]  devh_reg;
  reg [7:0]  ctrl_reg;

  // sequencing and queue bookkeeping
  reg [3:0]  cnt_reg;
  reg        relint_reg;
  reg        pend_reg;
  reg        cur_q_reg;
  reg [4:0]  cur_tag_reg;
  reg [31:0] queued_reg;
  reg [31:0] ready_reg;
  reg [15:0] pkt_word_reg;

  wire wr_en = psel & penable & pwrite;
  wire rd_en = psel & penable & ~pwrite;
  wire [4:0] idx = paddr[6:2];
  wire in_map = (paddr[11:7] == 5'h00) && (paddr[1:0] == 2'b00)
                && (idx <= `POQ_A_QSTAT);
  wire [7:0] wbyte = pwdata[7:0];
  wire selected = (devh_reg[`POQ_DEV_SEL] == dev_num);
  wire bsy = stat_reg[`POQ_ST_BSY];
  wire drq = stat_reg[`POQ_ST_DRQ];
  wire cmd_wr = wr_en & in_map & (idx == `POQ_A_CMD) & selected;
  wire st_rd = rd_en & in_map & (idx == `POQ_A_CMD) & selected;
  wire srst = wr_en & in_map & (idx == `POQ_A_CTRL)
              & wbyte[`POQ_CTL_SRST];
  wire q_any = |queued_reg;
  wire rdy_any = |ready_reg;

  // one-hot bit for a tag
  function [31:0] tag_bit;
    input [4:0] t;
    begin
      tag_bit = 32'h0000_0001 << t;
    end
  endfunction

  // classify overlappable commands
  function is_ovl_cmd;
    input [7:0] c;
    input [7:0] f;
    begin
      is_ovl_cmd = (c == `POQ_C_PACKET) || (c == `POQ_C_RDQ) ||
                   (c == `POQ_C_WRQ) || (c == `POQ_C_SERVICE) ||
                   ((c == `POQ_C_NOP) && (f == `POQ_SUB_POLL));
    end
  endfunction

  assign pready = 1'b1;
  assign pslverr = (psel & penable) & ~in_map;

  always @* begin
    prdata = 32'h0000_0000;
    case (idx)
      `POQ_A_DATA:  prdata = {16'h0000, pkt_word_reg};
      `POQ_A_FEAT:  prdata = {24'h000000, err_reg};
      `POQ_A_SCNT:  prdata = {24'h000000, scnt_reg};
      `POQ_A_LBAL:  prdata = {24'h000000, lbal_reg};
      `POQ_A_LBAM:  prdata = {24'h000000, lbam_reg};
      `POQ_A_LBAH:  prdata = {24'h000000, lbah_reg};
      `POQ_A_DEVH:  prdata = {24'h000000, devh_reg};
      `POQ_A_CMD:   prdata = selected ? {24'h000000, stat_reg}
                                      : 32'h0000_0000;
      `POQ_A_CTRL:  prdata = {24'h000000, ctrl_reg};
      `POQ_A_ENG:   prdata = {29'h0, state_reg};
      // queue depth as identify word 73
      `POQ_A_QSTAT: prdata = {9'h0, `POQ_ID_QWORD, 11'h0, `POQ_QDEPTH};
      default:      prdata = 32'h0000_0000;
    endcase
  end

  wire [31:0] ready_set = (eng_ready && queued_reg[eng_tag])
                          ? tag_bit(eng_tag) : 32'h0000_0000;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg      <= S_IDLE;
      stat_reg       <= 8'h00;
      err_reg        <= 8'h01;
      scnt_reg       <= `POQ_SIG_SCNT;
      lbal_reg       <= `POQ_SIG_LBAL;
      lbam_reg       <= `POQ_SIG_LBAM;
      lbah_reg       <= `POQ_SIG_LBAH;
      feat_reg       <= 8'h00;
      devh_reg       <= 8'h00;
      ctrl_reg       <= 8'h00;
      cnt_reg        <= 4'h0;
      relint_reg     <= 1'b0;
      pend_reg       <= 1'b0;
      cur_q_reg      <= 1'b0;
      cur_tag_reg    <= 5'h00;
      queued_reg     <= 32'h0000_0000;
      ready_reg      <= 32'h0000_0000;
      pkt_word_reg   <= 16'h0000;
      intrq          <= 1'b0;
      serv_ready_out <= 1'b0;
    end else begin
      ready_reg <= ready_reg | ready_set;
      // status read or command write clears pending
      if (st_rd || cmd_wr) begin
        pend_reg <= 1'b0;
      end

      // task-file writes land whether or not this device is selected
      if (wr_en && in_map && idx == `POQ_A_CTRL) begin
        ctrl_reg <= wbyte;
      end

      if (wr_en && in_map && idx == `POQ_A_DEVH) begin
        devh_reg <= wbyte;
      end

      if (wr_en && in_map && idx == `POQ_A_FEAT) begin
        feat_reg <= wbyte;
      end

      if (wr_en && in_map && idx == `POQ_A_SCNT) begin
        scnt_reg <= wbyte;
      end

      if (wr_en && in_map && idx == `POQ_A_LBAL) begin
        lbal_reg <= wbyte;
      end

      if (wr_en && in_map && idx == `POQ_A_LBAM) begin
        lbam_reg <= wbyte;
      end

      if (wr_en && in_map && idx == `POQ_A_LBAH) begin
        lbah_reg <= wbyte;
      end

      if (srst) begin
        // signature after soft reset; queue dropped too
        state_reg  <= S_IDLE;
        stat_reg   <= 8'h00;
        err_reg    <= 8'h01;
        scnt_reg   <= `POQ_SIG_SCNT;
        lbal_reg   <= `POQ_SIG_LBAL;
        lbam_reg   <= `POQ_SIG_LBAM;
        lbah_reg   <= `POQ_SIG_LBAH;
        queued_reg <= 32'h0000_0000;
        ready_reg  <= 32'h0000_0000;
        pend_reg   <= 1'b0;
      end else begin
        case (state_reg)
          S_IDLE: begin
            if (cmd_wr) begin
              err_reg <= 8'h00;
              stat_reg[`POQ_ST_ERR] <= 1'b0;
              // auto-poll nop: err only, queue untouched
              if (wbyte == `POQ_C_NOP && feat_reg == `POQ_SUB_POLL) begin
                stat_reg[`POQ_ST_ERR] <= 1'b1;
                err_reg  <= `POQ_ER_ABRT;
                pend_reg <= 1'b1;
              end else if (q_any && !is_ovl_cmd(wbyte, feat_reg)) begin
                stat_reg[`POQ_ST_ERR] <= 1'b1;
                err_reg    <= `POQ_ER_ABRT;
                queued_reg <= 32'h0000_0000;
                ready_reg  <= 32'h0000_0000;
                pend_reg   <= 1'b1;
              end else if (wbyte == `POQ_C_IDDEV) begin
                stat_reg[`POQ_ST_ERR] <= 1'b1;
                err_reg  <= `POQ_ER_ABRT;
                scnt_reg <= `POQ_SIG_SCNT;
                lbal_reg <= `POQ_SIG_LBAL;
                lbam_reg <= `POQ_SIG_LBAM;
                lbah_reg <= `POQ_SIG_LBAH;
                pend_reg <= 1'b1;
              end else if (wbyte == `POQ_C_SETF) begin
                if (feat_reg == `POQ_SF_RELEN)
                  relint_reg <= 1'b1;
                else if (feat_reg == `POQ_SF_RELDIS)
                  relint_reg <= 1'b0;
                pend_reg <= 1'b1;
              end else if (wbyte == `POQ_C_PACKET) begin
                // busy while preparing for the packet
                stat_reg[`POQ_ST_BSY] <= 1'b1;
                cnt_reg   <= 4'h0;
                cur_q_reg <= 1'b0;
                // released packet is tracked under the host's tag
                cur_tag_reg <= scnt_reg[4:0];
                state_reg <= S_PREP;
              end else if (wbyte == `POQ_C_RDQ || wbyte == `POQ_C_WRQ) begin
                if (queued_reg[scnt_reg[4:0]]) begin
                  stat_reg[`POQ_ST_ERR] <= 1'b1;
                  err_reg    <= `POQ_ER_ABRT;
                  queued_reg <= 32'h0000_0000;
                  ready_reg  <= 32'h0000_0000;
                  pend_reg   <= 1'b1;
                end else begin
                  cur_tag_reg <= scnt_reg[4:0];
                  cur_q_reg   <= 1'b1;
                  stat_reg[`POQ_ST_BSY] <= 1'b1;
                  state_reg   <= S_EXEC;
                end
              end else if (wbyte == `POQ_C_SERVICE && rdy_any) begin
                stat_reg[`POQ_ST_BSY] <= 1'b1;
                cur_q_reg <= 1'b1;
                state_reg <= S_EXEC;
              end else begin
                pend_reg <= 1'b1;
              end
            end
          end
          S_PREP: begin
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == `POQ_PREP_CYC) begin
              stat_reg[`POQ_ST_BSY] <= 1'b0;
              stat_reg[`POQ_ST_DRQ] <= 1'b1;
              cnt_reg   <= 4'h0;
              state_reg <= S_PKT;
            end
          end
          S_PKT: begin
            if (wr_en && in_map && idx == `POQ_A_DATA) begin
              pkt_word_reg <= pwdata[15:0];
              cnt_reg <= cnt_reg + 4'h1;
              // last word: busy on, drq off
              if (cnt_reg == `POQ_PKT_LAST) begin
                stat_reg[`POQ_ST_DRQ] <= 1'b0;
                stat_reg[`POQ_ST_BSY] <= 1'b1;
                state_reg <= S_EXEC;
              end
            end
          end
          S_EXEC: begin
            if (eng_error) begin
              stat_reg <= 8'h01;
              err_reg  <= `POQ_ER_ABRT;
              queued_reg <= 32'h0000_0000;
              ready_reg  <= 32'h0000_0000;
              pend_reg   <= 1'b1;
              state_reg  <= S_IDLE;
            end else if (cur_q_reg && rdy_any) begin
              scnt_reg <= {3'b000, eng_tag};
              queued_reg <= queued_reg & ~tag_bit(eng_tag);
              ready_reg <= (ready_reg | ready_set) & ~tag_bit(eng_tag);
              stat_reg[`POQ_ST_BSY] <= 1'b0;
              pend_reg  <= 1'b1;
              state_reg <= S_IDLE;
            end else if (eng_ready
                         && !(cur_q_reg || feat_reg[`POQ_FEAT_OVL])) begin
              stat_reg[`POQ_ST_BSY] <= 1'b0;
              pend_reg  <= 1'b1;
              state_reg <= S_IDLE;
            end else if (cur_q_reg || (feat_reg[`POQ_FEAT_OVL] && relint_reg)
                         || (feat_reg[`POQ_FEAT_OVL] && !eng_ready)) begin
              // release: busy and drq both clear
              stat_reg[`POQ_ST_BSY] <= 1'b0;
              stat_reg[`POQ_ST_DRQ] <= 1'b0;
              queued_reg <= queued_reg | tag_bit(cur_tag_reg);
              if (relint_reg)
                pend_reg <= 1'b1;
              state_reg <= S_IDLE;
            end else if (eng_ready) begin
              stat_reg[`POQ_ST_BSY] <= 1'b0;
              pend_reg  <= 1'b1;
              state_reg <= S_IDLE;
            end
          end
          default: state_reg <= S_IDLE;
        endcase
      end
      // serv flag; interrupt only when ready while idle
      stat_reg[`POQ_ST_SERV] <= rdy_any | (|ready_set);
      if ((|ready_set) && !rdy_any && !bsy && !drq && state_reg == S_IDLE)
        pend_reg <= 1'b1;
      // intrq gated by selection and nien
      intrq <= pend_reg & selected & ~ctrl_reg[`POQ_CTL_NIEN];
      serv_ready_out <= rdy_any & selected;
    end
  end

endmodule // poq_core

`default_nettype wire

// [common/poq_defines.vh]
// constants for the packet, overlap and queue control block
//
// Contract
// - after any reset the task file holds the packet-device signature; the code loads it on presetn and soft reset only, not on device reset 08h.
// - identify device is aborted and the packet signature is loaded.
// - packet command sets busy, then data request with busy cleared.
// - after the last packet word busy sets and data request clears.
// - bus release clears both data request and busy.
// - only nop 01h, packet, queued dma and service may overlap.
// - overlap with release interrupt: release, then serv and intrq.
// - overlap without release interrupt: complete now or release.
// - queued dma completes at once if ready, otherwise releases.
// - service need is shown only while the device is selected.
// - auto-poll nop returns err only and aborts nothing.
// - non-queued command with a queue aborts it and empties the queue.
// - maximum queue depth is reported in identify word 73.
// - host tag from sector count is restored during service.
// - duplicate tag or any error other than auto-poll nop aborts the whole queue.
// - ready while idle sets serv and pending interrupt, gated intrq.
// - status read or command write clears pending interrupt.
// - ready while busy only sets serv, no extra interrupt.
`ifndef POQ_DEFINES_VH
`define POQ_DEFINES_VH

`define POQ_A_DATA     5'h00
`define POQ_A_FEAT     5'h01
`define POQ_A_SCNT     5'h02
`define POQ_A_LBAL     5'h03
`define POQ_A_LBAM     5'h04
`define POQ_A_LBAH     5'h05
`define POQ_A_DEVH     5'h06
`define POQ_A_CMD      5'h07
`define POQ_A_CTRL     5'h08
`define POQ_A_ENG      5'h09
`define POQ_A_QSTAT    5'h0A

`define POQ_C_NOP      8'h00
`define POQ_C_PACKET   8'hA0
`define POQ_C_IDDEV    8'hEC
`define POQ_C_IDPKT    8'hA1
`define POQ_C_SERVICE  8'hA2
`define POQ_C_RDQ      8'hC7
`define POQ_C_WRQ      8'hCC
`define POQ_C_SETF     8'hEF
`define POQ_C_DEVRST   8'h08
`define POQ_SUB_POLL   8'h01
`define POQ_SF_RELEN   8'h5D
`define POQ_SF_RELDIS  8'hDD

`define POQ_ST_BSY     7
`define POQ_ST_DRQ     3
`define POQ_ST_SERV    4
`define POQ_ST_ERR     0
`define POQ_ST_DRDY    6
`define POQ_ER_ABRT    8'h04
`define POQ_DEV_SEL    4
`define POQ_CTL_NIEN   1
`define POQ_CTL_SRST   2
`define POQ_FEAT_OVL   1

`define POQ_SIG_SCNT   8'h01
`define POQ_SIG_LBAL   8'h01
`define POQ_SIG_LBAM   8'h14
`define POQ_SIG_LBAH   8'hEB
`define POQ_PKT_WORDS  4'h6
`define POQ_PKT_LAST   4'h5
`define POQ_QDEPTH     5'h1F
`define POQ_ID_QWORD   7'd73
`define POQ_PREP_CYC   4'h4

`endif

// [testbench/poq_core_chk.sv]
// port assertions for the packet, overlap and queue control block
`default_nettype none
module poq_core_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        dev_num,
  input wire logic        intrq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic      nien_h;
  logic      nien_d;
  logic      devh_h;
  logic      devh_d;
  logic      wrote;
  wire logic acc = psel && penable;
  wire logic sel = devh_d == dev_num;
  wire logic sel_now = devh_h == dev_num;
  wire logic st_rd = acc && !pwrite && paddr == 12'h01C && sel_now;
  wire logic cmd_wr = acc && pwrite && paddr == 12'h01C && sel_now;
  // delayed copies: intrq is registered one cycle behind the registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nien_h <= 1'b0;
      nien_d <= 1'b0;
      devh_h <= 1'b0;
      devh_d <= 1'b0;
      wrote  <= 1'b0;
    end else begin
      if (acc && pwrite && paddr == 12'h020) nien_h <= pwdata[1];
      if (acc && pwrite && paddr == 12'h018) devh_h <= pwdata[4];
      if (acc && pwrite) wrote <= 1'b1;
      nien_d <= nien_h;
      devh_d <= devh_h;
    end
  end
  chk_ready_up: assert property (@(posedge pclk) disable iff (!presetn)
    acc |-> pready) else $error("pready low in access phase");
  chk_map_err: assert property (@(posedge pclk) disable iff (!presetn)
    acc && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 12'h028))
    else $error("pslverr wrong for address");
  chk_sig_reset: assert property (
    @(posedge pclk) disable iff (!presetn)
    acc && !pwrite && !wrote && (paddr == 12'h010 || paddr == 12'h014)
    |-> prdata[7:0] == (paddr == 12'h010 ? 8'h14 : 8'hEB))
    else $error("signature missing after reset");
  chk_no_both: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_rd |-> !(prdata[7] && prdata[3])) else $error("busy with drq");
  chk_rd_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    st_rd && intrq |=> ##1 !intrq) else $error("intrq kept after read");
  chk_wr_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    cmd_wr && pwdata[7:0] == 8'hA0 |=> ##1 !intrq)
    else $error("intrq kept after command");
  chk_nien_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(intrq) |-> !nien_d) else $error("intrq with nien set");
  chk_sel_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    intrq |-> sel) else $error("intrq while not selected");
endmodule // poq_core_chk
bind poq_core poq_core_chk poq_core_chk_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .dev_num(dev_num), .intrq(intrq));
`default_nettype wire

// [testbench/poq_eng_model.sv]
// media engine stand-in that reports a command ready after a delay
`default_nettype none
module poq_eng_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       go,
  input  wire logic [4:0] tag_in,
  output logic            eng_ready,
  output logic [4:0]      eng_tag,
  output logic            eng_error
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] dly_reg;
  // tag toggles when idle so a stale tag is never mistaken for valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_reg   <= 4'hA;
      eng_ready <= 1'b0;
      eng_tag   <= 5'h00;
    end else if (!go) begin
      dly_reg   <= 4'hA;
      eng_ready <= 1'b0;
      eng_tag   <= ~eng_tag;
    end else if (dly_reg != 4'h0) begin
      dly_reg <= dly_reg - 4'h1;
      eng_tag <= ~eng_tag;
    end else begin
      eng_ready <= 1'b1;
      eng_tag   <= tag_in;
    end
  end
  assign eng_error = 1'b0;
endmodule // poq_eng_model
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench for the packet, overlap and queue control block
`include "poq_defines.vh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] BSY = 8'h01 << `POQ_ST_BSY;
  localparam logic [7:0] DRQ = 8'h01 << `POQ_ST_DRQ;
  localparam logic [7:0] SRV = 8'h01 << `POQ_ST_SERV;
  localparam logic [7:0] ERR = 8'h01 << `POQ_ST_ERR;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        eng_go = 1'b0;
  wire logic [31:0] prdata;
  wire logic        pready;
  wire logic        pslverr;
  wire logic        intrq;
  wire logic        serv_out;
  wire logic        eng_ready;
  wire logic [4:0]  eng_tag;
  wire logic        eng_error;
  logic [31:0] rd;
  logic        rd_err;
  int          err_total = 0;
  int          tests_run = 0;
  always #4 pclk = ~pclk;
  poq_core poq_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dev_num(1'b0),
    .eng_ready(eng_ready), .eng_tag(eng_tag), .eng_error(eng_error),
    .intrq(intrq), .serv_ready_out(serv_out));
  poq_eng_model poq_eng_model_inst (.pclk(pclk), .presetn(presetn),
    .go(eng_go), .tag_in(5'h01), .eng_ready(eng_ready),
    .eng_tag(eng_tag), .eng_error(eng_error));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    rd_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] i, input logic [7:0] d);
    apb(1'b1, {5'h00, i, 2'b00}, {24'h0, d});
  endtask
  task automatic rdm(input logic [4:0] i, input logic [7:0] m,
                     input logic [7:0] v);
    apb(1'b0, {5'h00, i, 2'b00}, 32'h0);
    check({24'h0, rd[7:0] & m}, {24'h0, v});
  endtask
  task automatic poll(input logic [7:0] m, input logic [7:0] v);
    int n;
    n = 0;
    do begin
      apb(1'b0, {5'h00, `POQ_A_CMD, 2'b00}, 32'h0);
      n++;
    end while ((rd[7:0] & m) !== v && n < 200);
    check({24'h0, rd[7:0] & m}, {24'h0, v});
  endtask
  task automatic send_pkt;
    // packet words go over pio data writes
    for (int k = 0; k < 6; k++) wr(`POQ_A_DATA, 8'(k));
  endtask
  task automatic t_reset_sig;
    rdm(`POQ_A_SCNT, 8'hFF, `POQ_SIG_SCNT);
    rdm(`POQ_A_LBAL, 8'hFF, `POQ_SIG_LBAL);
    rdm(`POQ_A_LBAM, 8'hFF, `POQ_SIG_LBAM);
    rdm(`POQ_A_LBAH, 8'hFF, `POQ_SIG_LBAH);
    apb(1'b0, 12'h02C, 32'h0);
    check({31'h0, rd_err}, 32'h1);
    wr(`POQ_A_DEVH, 8'h00);
    wr(`POQ_A_CTRL, 8'h00);
  endtask
  task automatic t_identify;
    wr(`POQ_A_LBAM, 8'h00);
    wr(`POQ_A_CMD, `POQ_C_IDDEV);
    poll(BSY | ERR, ERR);
    rdm(`POQ_A_FEAT, 8'hFF, `POQ_ER_ABRT);
    rdm(`POQ_A_LBAM, 8'hFF, `POQ_SIG_LBAM);
  endtask
  task automatic t_nop_poll;
    wr(`POQ_A_FEAT, `POQ_SUB_POLL);
    wr(`POQ_A_CMD, `POQ_C_NOP);
    poll(BSY | ERR, ERR);
  endtask
  task automatic t_packet;
    // no soft reset is issued while the packet command runs
    wr(`POQ_A_FEAT, 8'h00);
    wr(`POQ_A_CMD, `POQ_C_PACKET);
    rdm(`POQ_A_CMD, BSY | DRQ, BSY);
    poll(BSY | DRQ, DRQ);
    send_pkt;
    rdm(`POQ_A_CMD, BSY | DRQ, BSY);
    eng_go <= 1'b1;
    poll(BSY | DRQ | ERR, 8'h00);
    eng_go <= 1'b0;
  endtask
  task automatic t_overlap;
    int n;
    wr(`POQ_A_FEAT, `POQ_SF_RELEN);
    wr(`POQ_A_CMD, `POQ_C_SETF);
    poll(BSY, 8'h00);
    wr(`POQ_A_FEAT, 8'h01 << `POQ_FEAT_OVL);
    wr(`POQ_A_CMD, `POQ_C_PACKET);
    poll(BSY | DRQ, DRQ);
    send_pkt;
    poll(BSY | DRQ, 8'h00);
    rdm(`POQ_A_CMD, SRV, 8'h00);
    eng_go <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (intrq !== 1'b1 && n < 100);
    check({31'h0, intrq}, 32'h1);
    rdm(`POQ_A_CMD, SRV, SRV);
    check({31'h0, serv_out}, 32'h1);
    repeat (2) @(posedge pclk);
    check({31'h0, intrq}, 32'h0);
    wr(`POQ_A_CMD, `POQ_C_SERVICE);
    poll(BSY | DRQ, 8'h00);
    eng_go <= 1'b0;
  endtask
  task automatic t_queue;
    wr(`POQ_A_CTRL, 8'h01 << `POQ_CTL_NIEN);
    wr(`POQ_A_SCNT, 8'h08);
    wr(`POQ_A_CMD, `POQ_C_RDQ);
    poll(BSY | DRQ | ERR, 8'h00);
    wr(`POQ_A_CMD, `POQ_C_WRQ);
    poll(BSY | ERR, ERR);
    rdm(`POQ_A_FEAT, 8'hFF, `POQ_ER_ABRT);
    wr(`POQ_A_SCNT, 8'h10);
    wr(`POQ_A_CMD, `POQ_C_RDQ);
    poll(BSY | DRQ | ERR, 8'h00);
    wr(`POQ_A_CMD, `POQ_C_IDPKT);
    poll(BSY | ERR, ERR);
    rdm(`POQ_A_FEAT, 8'hFF, `POQ_ER_ABRT);
    apb(1'b0, {5'h00, `POQ_A_QSTAT, 2'b00}, 32'h0);
    check(rd, {9'h0, `POQ_ID_QWORD, 11'h0, `POQ_QDEPTH});
    // nien is still set, now select the other device
    wr(`POQ_A_DEVH, 8'h10);
    rdm(`POQ_A_CMD, 8'hFF, 8'h00);
    check({31'h0, intrq}, 32'h0);
    wr(`POQ_A_DEVH, 8'h00);
  endtask
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #400000;
    err_total++;
    print_verdict;
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_sig;
    t_identify;
    t_nop_poll;
    t_packet;
    t_overlap;
    t_queue;
    print_verdict;
  end
endmodule // testbench
`default_nettype wire
